// *** core/altcnt_pkg.sv ***
package altcnt_pkg;
   // ***********************
   // Register map
   // ***********************
   localparam logic [3:0]  ALT_COUNT_OFFSET   = 4'h0;
   localparam logic [3:0]  SEGMENT_OFFSET     = 4'h4;
   localparam logic [3:0]  STATUS_OFFSET      = 4'h8;
   localparam int          ADDR_WIDTH         = 4;
   // ***********************
   // Alternate count fields
   // ***********************
   localparam int          REVISION_MSB       = 15;
   localparam int          REVISION_LSB       = 13;
   localparam int          RSVD_MSB           = 12;
   localparam int          RSVD_LSB           = 10;
   localparam int          FIRST_SEL_BIT      = 9;
   localparam int          SECOND_SEL_BIT     = 8;
   localparam int          COUNT_MSB          = 7;
   localparam int          COUNT_LSB          = 0;
   localparam logic [15:0] ALT_WRITE_MASK     = 16'h03ff;
   localparam logic [15:0] ALT_RESET          = 16'h0000;
   // ***********************
   // Segment register fields
   // ***********************
   localparam int          BOOT_BIT           = 6;
   localparam int          SEG_MSB            = 4;
   localparam int          SEG_LSB            = 0;
   localparam logic [15:0] SEG_WRITE_MASK     = 16'h005f;
   localparam logic [15:0] SEG_RESET          = 16'h0040;
   // ***********************
   // Status register fields
   // ***********************
   localparam int          ST_BUSY_BIT        = 0;
   localparam int          ST_FETCH_EN_BIT    = 1;
   // ***********************
   // Checksum and response codes
   // ***********************
   localparam logic [31:0] CRC32_POLY         = 32'hedb88320;
   localparam logic [1:0]  RESP_OKAY          = 2'b00;
   localparam logic [1:0]  RESP_SLVERR        = 2'b10;
endpackage

// *** core/crc32_byte_step.sv ***
module crc32_byte_step (
   input  wire logic [31:0] seed_i,   // Running partial result
   input  wire logic [7:0]  data_i,   // Byte to fold in
   output logic      [31:0] crc_o     // Updated partial result
);
   // ***********************
   // One byte, reflected CRC32
   // ***********************
   always_comb
   begin
      logic [31:0] c;
      c = seed_i ^ {24'h000000, data_i};
      for (int i = 0; i < 8; i++)
      begin
         c = c[0] ? ((c >> 1) ^ altcnt_pkg::CRC32_POLY) : (c >> 1);
      end
      crc_o = c;
   end
endmodule

// *** core/dma_alt_count_and_segment_regs.sv ***
// Functional notes
// - Alternate option takes count, selects from register
// - Top three bits: fixed read-only revision
// - Bits twelve to ten read zero
// - First select: CRC32 seeded from first register
// - X bit gates first partial update; Y bit only drives second select output
module dma_alt_count_and_segment_regs #(
   parameter logic [2:0] SILICON_REVISION = 3'h5   // Arbitrary identity value
) (
   input  wire logic        clk_i,            // 100 MHz clock
   input  wire logic        rst_b_i,          // Async reset, active low
   input  wire logic [3:0]  s_axi_awaddr,     // Write address
   input  wire logic        s_axi_awvalid,    // Write address valid
   output logic             s_axi_awready,    // Write address ready
   input  wire logic [31:0] s_axi_wdata,      // Write data
   input  wire logic [3:0]  s_axi_wstrb,      // Write strobes
   input  wire logic        s_axi_wvalid,     // Write data valid
   output logic             s_axi_wready,     // Write data ready
   output logic [1:0]       s_axi_bresp,      // Write response
   output logic             s_axi_bvalid,     // Write response valid
   input  wire logic        s_axi_bready,     // Write response ready
   input  wire logic [3:0]  s_axi_araddr,     // Read address
   input  wire logic        s_axi_arvalid,    // Read address valid
   output logic             s_axi_arready,    // Read address ready
   output logic [31:0]      s_axi_rdata,      // Read data
   output logic [1:0]       s_axi_rresp,      // Read response
   output logic             s_axi_rvalid,     // Read data valid
   input  wire logic        s_axi_rready,     // Read data ready
   input  wire logic        dma_start_i,      // DMA instruction issued
   input  wire logic        alternate_count_option_i,  // Instruction uses alternate count
   input  wire logic [7:0]  instr_count_i,    // Count from instruction
   input  wire logic        instr_first_sel_i,   // Instruction first select
   input  wire logic        instr_second_sel_i,  // Instruction second select
   input  wire logic        dma_byte_valid_i, // Byte moving through port
   input  wire logic [7:0]  dma_byte_i,       // That byte
   input  wire logic [31:0] first_partial_checksum_reg_i,  // Current first partial result
   input  wire logic        boot_done_i,      // Boot routine finished
   output logic [7:0]       dma_count_o,      // Count used by running DMA
   output logic             dma_first_checksum_select_o,   // First set in use
   output logic             dma_second_checksum_select_o,  // Second set in use
   output logic [31:0]      first_partial_checksum_o,      // Write-back value
   output logic             first_partial_we_o,            // Write-back strobe
   output logic [4:0]       fetch_segment_o,  // Fetch segment
   output logic             user_exec_en_o    // User execution allowed
);
   // ***********************
   // Reset release
   // ***********************
   logic [1:0] rst_sync_q;
   logic       rst_n;
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // ***********************
   // State
   // ***********************
   typedef struct packed {
      logic        aw_have;
      logic [3:0]  aw_addr;
      logic        w_have;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [15:0] alt;
      logic [15:0] seg;
      logic        busy;
      logic [7:0]  count;
      logic        sel_x;
      logic        sel_y;
      logic [31:0] crc;
      logic        crc_we;
      logic [4:0]  fetch;
      logic        user_en;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic [31:0] crc_next;
   logic [15:0] alt_view;
   logic [15:0] wr_val;

   crc32_byte_step u_step (
      .seed_i (s_q.crc),
      .data_i (dma_byte_i),
      .crc_o  (crc_next)
   );

   assign alt_view = {SILICON_REVISION, 3'h0, s_q.alt[altcnt_pkg::FIRST_SEL_BIT:altcnt_pkg::COUNT_LSB]};

   always_comb
   begin
      logic wr_go;
      logic [15:0] wm;
      wr_go  = 1'b0;
      wm     = 16'h0000;
      s_d    = s_q;
      wr_val = 16'h0000;
      s_d.crc_we = 1'b0;
      // Write channel: take address and data in either order
      if (s_axi_awvalid && s_q.awready)
      begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
         s_d.awready = 1'b0;
      end
      if (s_axi_wvalid && s_q.wready)
      begin
         s_d.w_have = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
         s_d.wready = 1'b0;
      end
      if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
      begin
         wr_go = 1'b1;
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = altcnt_pkg::RESP_OKAY;
      end
      if (s_q.bvalid && s_axi_bready)
      begin
         s_d.bvalid  = 1'b0;
         s_d.awready = 1'b1;
         s_d.wready  = 1'b1;
      end
      for (int b = 0; b < 2; b++)
      begin
         wm[b*8 +: 8] = {8{s_q.w_strb[b]}};
      end
      if (wr_go)
      begin
         unique case (s_q.aw_addr)
            altcnt_pkg::ALT_COUNT_OFFSET:
            begin
               wm = wm & altcnt_pkg::ALT_WRITE_MASK;
               wr_val = (s_q.alt & ~wm) | (s_q.w_data[15:0] & wm);
               s_d.alt = wr_val;
            end
            altcnt_pkg::SEGMENT_OFFSET:
            begin
               wm = wm & altcnt_pkg::SEG_WRITE_MASK;
               wr_val = (s_q.seg & ~wm) | (s_q.w_data[15:0] & wm);
               s_d.seg = wr_val;
            end
            default:
               s_d.bresp = altcnt_pkg::RESP_SLVERR;
         endcase
      end
      if (boot_done_i)
         s_d.seg[altcnt_pkg::BOOT_BIT] = 1'b0;
      // Read channel
      if (s_axi_arvalid && s_q.arready)
      begin
         s_d.arready = 1'b0;
         s_d.rvalid  = 1'b1;
         s_d.rresp   = altcnt_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            altcnt_pkg::ALT_COUNT_OFFSET:
               s_d.rdata = {16'h0000, alt_view};
            altcnt_pkg::SEGMENT_OFFSET:
               s_d.rdata = {16'h0000, s_q.seg};
            altcnt_pkg::STATUS_OFFSET:
               s_d.rdata = {30'h0, s_q.user_en, s_q.busy};
            default:
            begin
               s_d.rdata = 32'h00000000;
               s_d.rresp = altcnt_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s_q.rvalid && s_axi_rready)
      begin
         s_d.rvalid  = 1'b0;
         s_d.arready = 1'b1;
      end
      if (dma_start_i)
      begin
         s_d.busy = 1'b1;
         if (alternate_count_option_i)
         begin
            s_d.count = s_q.alt[altcnt_pkg::COUNT_MSB:altcnt_pkg::COUNT_LSB];
            s_d.sel_x = s_q.alt[altcnt_pkg::FIRST_SEL_BIT];
            s_d.sel_y = s_q.alt[altcnt_pkg::SECOND_SEL_BIT];
         end
         else
         begin
            s_d.count = instr_count_i;
            s_d.sel_x = instr_first_sel_i;
            s_d.sel_y = instr_second_sel_i;
         end
         s_d.crc = first_partial_checksum_reg_i;
      end
      else if (s_q.busy && dma_byte_valid_i)
      begin
         if (s_q.sel_x)
         begin
            s_d.crc    = crc_next;
            s_d.crc_we = 1'b1;
         end
         s_d.count = s_q.count - 8'h01;
         if (s_q.count == 8'h01 || s_q.count == 8'h00)
            s_d.busy = 1'b0;
      end
      s_d.fetch   = s_d.seg[altcnt_pkg::SEG_MSB:altcnt_pkg::SEG_LSB];
      s_d.user_en = ~s_d.seg[altcnt_pkg::BOOT_BIT];
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q         <= '0;
         s_q.awready <= 1'b1;
         s_q.wready  <= 1'b1;
         s_q.arready <= 1'b1;
         s_q.alt     <= altcnt_pkg::ALT_RESET;
         s_q.seg     <= altcnt_pkg::SEG_RESET;
      end
      else
         s_q <= s_d;
   end

   assign s_axi_awready = s_q.awready;
   assign s_axi_wready  = s_q.wready;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;
   assign dma_count_o   = s_q.count;
   assign dma_first_checksum_select_o  = s_q.sel_x;
   assign dma_second_checksum_select_o = s_q.sel_y;
   assign first_partial_checksum_o     = s_q.crc;
   assign first_partial_we_o           = s_q.crc_we;
   assign fetch_segment_o = s_q.fetch;
   assign user_exec_en_o  = s_q.user_en;

   // ***********************
   // Checks
   // ***********************
   AST_ALT_COUNT: assert property (@(posedge clk_i) disable iff (!rst_n)
      dma_start_i && alternate_count_option_i |=>
      dma_count_o == $past(s_q.alt[altcnt_pkg::COUNT_MSB:altcnt_pkg::COUNT_LSB]))
      else $error("Alternate count not taken");
   AST_ALT_SEL: assert property (@(posedge clk_i) disable iff (!rst_n)
      dma_start_i && alternate_count_option_i |=>
      {dma_first_checksum_select_o, dma_second_checksum_select_o} ==
      $past(s_q.alt[altcnt_pkg::FIRST_SEL_BIT:altcnt_pkg::SECOND_SEL_BIT]))
      else $error("Alternate select not taken");
   AST_REV_RD: assert property (@(posedge clk_i) disable iff (!rst_n)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == altcnt_pkg::ALT_COUNT_OFFSET |=>
      s_axi_rdata[altcnt_pkg::REVISION_MSB:altcnt_pkg::REVISION_LSB] == SILICON_REVISION)
      else $error("Revision field wrong");
   AST_RSVD_RD: assert property (@(posedge clk_i) disable iff (!rst_n)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == altcnt_pkg::ALT_COUNT_OFFSET |=>
      s_axi_rdata[altcnt_pkg::RSVD_MSB:altcnt_pkg::RSVD_LSB] == 3'h0)
      else $error("Reserved bits not zero");
   AST_CRC_SEED: assert property (@(posedge clk_i) disable iff (!rst_n)
      dma_start_i |=> first_partial_checksum_o == $past(first_partial_checksum_reg_i))
      else $error("Seed not loaded");
   AST_CRC_WB: assert property (@(posedge clk_i) disable iff (!rst_n)
      !dma_start_i && s_q.busy && dma_byte_valid_i && s_q.sel_x |=> first_partial_we_o)
      else $error("No write-back");
   AST_SEG: assert property (@(posedge clk_i) disable iff (!rst_n)
      ##1 fetch_segment_o == $past(s_d.seg[altcnt_pkg::SEG_MSB:altcnt_pkg::SEG_LSB]))
      else $error("Fetch segment mismatch");
   AST_BOOT: assert property (@(posedge clk_i) disable iff (!rst_n)
      boot_done_i |=> user_exec_en_o)
      else $error("Boot flag not cleared");
endmodule

// *** bench/tb.sv ***
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ***********************
   // Signals
   // ***********************
   localparam logic [2:0] REVISION_CODE = 3'h5;  // Arbitrary revision code
   logic clk_i = 0, rst_b_i = 0;
   logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rdata, seed = 0, crc;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic start = 0, alt_opt = 0, isel1 = 0, isel2 = 0, bval = 0, boot_done = 0;
   logic [7:0] icount = 0, dbyte = 0, count;
   logic sel1, sel2, we, exec_en;
   logic [31:0] pcrc, got;
   logic [4:0] seg;
   int failures = 0, n_checks = 0, cycles = 0;
   typedef struct {logic [3:0] a; logic [31:0] w; logic [31:0] r;} row_t;
   row_t rows[5] = '{'{4'h0, 32'hffffe3ff, {16'h0, REVISION_CODE, 13'h03ff}},
                     '{4'h0, 32'h0000e000, {16'h0, REVISION_CODE, 13'h0}},
                     '{4'h0, 32'h00000155, {16'h0, REVISION_CODE, 13'h0155}},
                     '{4'h4, 32'hffffffff, 32'h0000005f}, '{4'h4, 32'h00000053, 32'h00000053}};
   always #5 clk_i = ~clk_i;
   dma_alt_count_and_segment_regs #(.SILICON_REVISION(REVISION_CODE)) dma_alt_count_and_segment_regs_inst (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dma_start_i(start), .alternate_count_option_i(alt_opt),
      .instr_count_i(icount), .instr_first_sel_i(isel1), .instr_second_sel_i(isel2), .dma_byte_valid_i(bval),
      .dma_byte_i(dbyte), .first_partial_checksum_reg_i(seed), .boot_done_i(boot_done), .dma_count_o(count),
      .dma_first_checksum_select_o(sel1), .dma_second_checksum_select_o(sel2),
      .first_partial_checksum_o(pcrc), .first_partial_we_o(we), .fetch_segment_o(seg),
      .user_exec_en_o(exec_en));
   // ***********************
   // Helpers
   // ***********************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
         failures++;
      end
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Leading edge keeps a strobe from being raised in the step that lowered it
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
      do
      begin
         @(posedge clk_i);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
      end
      while (!(bvalid === 1'b1 && bready));
      r = bresp;
      bready <= 0;
   endtask
   task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      araddr <= a; arvalid <= 1; rready <= 1;
      do
      begin
         @(posedge clk_i);
         if (arvalid && arready) arvalid <= 0;
      end
      while (!(rvalid === 1'b1 && rready));
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
      c = c ^ {24'h0, b};
      for (int i = 0; i < 8; i++)
         c = c[0] ? (c >> 1) ^ altcnt_pkg::CRC32_POLY : c >> 1;
      return c;
   endfunction
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         stop_test();
      end
   end
   // ***********************
   // Sequence
   // ***********************
   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1;
      repeat (3) @(posedge clk_i);
      axi_read(4'h0, got, resp);
      chk(got, {16'h0, REVISION_CODE, 13'h0});
      axi_read(4'h4, got, resp);
      chk(got, 32'h00000040);
      chk({31'h0, exec_en}, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         axi_write(rows[i].a, rows[i].w, resp);
         chk({30'h0, resp}, {30'h0, altcnt_pkg::RESP_OKAY});
         axi_read(rows[i].a, got, resp);
         chk(got, rows[i].r);
         if (rows[i].a == 4'h4) chk({27'h0, seg}, {27'h0, rows[i].w[4:0]});
      end
      axi_read(4'hc, got, resp);
      chk({got[29:0], resp}, {30'h0, altcnt_pkg::RESP_SLVERR});
      axi_write(4'hc, 32'h0000ffff, resp);
      chk({30'h0, resp}, {30'h0, altcnt_pkg::RESP_SLVERR});
      // Boot completion releases user execution
      @(posedge clk_i) boot_done <= 1;
      @(posedge clk_i) boot_done <= 0;
      repeat (2) @(posedge clk_i);
      chk({31'h0, exec_en}, 32'h1);
      axi_read(4'h4, got, resp);
      chk(got, 32'h00000013);
      axi_read(4'h8, got, resp);
      chk(got, 32'h00000002);
      // Alternate count run: instruction fields must be ignored
      axi_write(4'h0, 32'h00000203, resp);
      @(posedge clk_i);
      start <= 1; alt_opt <= 1; icount <= 8'h55; isel2 <= 1; seed <= 32'hffffffff;
      @(posedge clk_i) start <= 0;
      @(posedge clk_i);
      chk({22'h0, sel1, sel2, count}, {22'h0, 2'b10, 8'h03});
      crc = 32'hffffffff;
      for (int i = 0; i < 3; i++)
      begin
         bval <= 1; dbyte <= 8'h31 + 8'(i);
         crc = crc_step(crc, 8'h31 + 8'(i));
         @(posedge clk_i) bval <= 0;
         for (int k = 0; k < 4 && we !== 1'b1; k++) @(posedge clk_i);
         chk(pcrc, crc);
         chk({31'h0, we}, 32'h1);
      end
      @(posedge clk_i);
      chk({24'h0, count}, 32'h0);
      // Plain run takes instruction fields
      start <= 1; alt_opt <= 0; icount <= 8'h02; isel1 <= 0; isel2 <= 1;
      @(posedge clk_i) start <= 0;
      @(posedge clk_i);
      chk({22'h0, sel1, sel2, count}, {22'h0, 2'b01, 8'h02});
      // Mid-run reset restores boot state and clears the count register
      rst_b_i <= 0;
      @(posedge clk_i) rst_b_i <= 1;
      repeat (3) @(posedge clk_i);
      chk({31'h0, exec_en}, 32'h0);
      chk({27'h0, seg}, 32'h0);
      axi_read(4'h0, got, resp);
      chk(got, {16'h0, REVISION_CODE, 13'h0});
      stop_test();
   end
endmodule
